/* shared/rps_pkg.sv */
package rps_pkg;
    localparam int unsigned NUM_CH = 24;
    localparam logic [4:0]  LAST_CH = 5'h17;

    // Register indexes; the bus byte address is four times the index
    localparam logic [7:0] IDX_PAYLOAD_CFG  = 8'hD0;
    localparam logic [7:0] IDX_CTRL_EN      = 8'hD1;
    localparam logic [7:0] IDX_SIG_CFG      = 8'hD2;
    localparam logic [7:0] IDX_ACC_STATUS   = 8'hD3;
    localparam logic [7:0] IDX_ACC_CTRL     = 8'hD4;
    localparam logic [7:0] IDX_ACC_DATA     = 8'hD5;
    localparam logic [7:0] IDX_FLAGS_LO     = 8'hD6;
    localparam logic [7:0] IDX_FLAGS_MID    = 8'hD7;
    localparam logic [7:0] IDX_FLAGS_HI     = 8'hD8;

    localparam logic [7:0] PAYLOAD_CFG_RST  = 8'h80;
    localparam logic [7:0] CTRL_EN_RST      = 8'h00;
    localparam logic [7:0] SIG_CFG_RST      = 8'h01;
    localparam logic [7:0] ACC_RST          = 8'h00;

    localparam int unsigned SNAP_BIT   = 7;
    localparam int unsigned GSTRK_BIT  = 6;
    localparam int unsigned GSUB_MSB   = 2;
    localparam int unsigned TWO_BIT_SIGNALING_PLACE_BIT   = 3;
    localparam int unsigned FIX_BIT    = 2;
    localparam int unsigned POL_BIT    = 1;
    localparam int unsigned PAYLOAD_CTRL_MASTER_EN_BIT   = 0;
    localparam int unsigned FREEZE_BIT = 3;
    localparam int unsigned DEB_BIT    = 2;
    localparam int unsigned SIGNALING_IRQ_EN_BIT   = 1;
    localparam int unsigned SIXTEEN_STATE_SEL_BIT   = 0;
    localparam int unsigned RWN_BIT    = 7;
    localparam int unsigned EXT_EN_BIT = 4;
    localparam int unsigned BUSY_BIT   = 0;

    localparam logic [6:0] IND_ADDR_MIN = 7'h01;
    localparam logic [6:0] IND_ADDR_MAX = 7'h18;
    localparam logic [7:0] STORE_RST    = 8'h10;

    localparam logic [2:0] SUB_NONE  = 3'h0;
    localparam logic [2:0] SUB_TRUNK = 3'h1;
    localparam logic [2:0] SUB_ALAW  = 3'h2;
    localparam logic [2:0] SUB_ULAW  = 3'h3;

    localparam logic [4:0] FR_FIRST = 5'h01;
    localparam logic [4:0] FR_A     = 5'h06;
    localparam logic [4:0] FR_B     = 5'h0C;
    localparam logic [4:0] FR_C     = 5'h12;
    localparam logic [4:0] FR_D     = 5'h18;

    localparam logic [7:0] ALAW_MW [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
                                           8'hB4, 8'hA1, 8'hA1, 8'hB4};
    localparam logic [7:0] ULAW_MW [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                           8'h9E, 8'h8B, 8'h8B, 8'h9E};

    typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_SLC96, FMT_OTHER} rps_fmt_t;
    typedef enum logic {IND_IDLE, IND_RUN} rps_ind_state_t;

    typedef struct packed {
        logic [4:0] chan;
        logic [4:0] frame;
        logic [7:0] data;
    } rps_slot_t;

    typedef struct packed {
        logic [2:0] channel_payload_substitution;
        logic [7:0] data_trunk_code;
        logic       strk_en;
        logic [3:0] strk_code;
    } rps_chctl_t;
endpackage : rps_pkg

/* core/rps_rx_payload_signaling_ctrl.sv */
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
module rps_rx_payload_signaling_ctrl
    import rps_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [11:0] WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    input  wire logic        SLOT_VALID_IN,
    input  wire rps_slot_t   SLOT_IN,
    input  wire rps_chctl_t  CH_CTRL_IN,
    input  wire rps_fmt_t    FORMAT_IN,
    input  wire logic        FRAME_SYNC_IN,
    output logic             SLOT_VALID_OUT,
    output logic      [7:0]  SLOT_DATA_OUT,
    output logic      [3:0]  SLOT_SIG_OUT,
    output logic             INT_OUT
);
    logic [7:0]     payload_cfg_q;
    logic [7:0]     ctrl_en_q;
    logic [7:0]     sig_cfg_q;
    logic [7:0]     acc_ctrl_q;
    logic [7:0]     acc_data_q;
    logic [23:0]    flags_q;
    logic           ack_q;
    logic [31:0]    rd_q;
    logic [31:0]    rd_d;
    rps_ind_state_t ind_q;
    logic [7:0]     store_q [NUM_CH];
    logic [3:0]     acc_q   [NUM_CH];
    logic [3:0]     prev_q  [NUM_CH];
    logic [3:0]     hold_q  [NUM_CH];
    logic [2:0]     phase_q;

    logic       req;
    logic       wr;
    logic [9:0] widx;
    logic       payload_ctrl_master_en;
    logic       sixteen;
    logic       sf_fmt;
    logic       ext_fmt;
    logic       in_ok;
    logic [4:0] ch;
    logic       done;
    logic       sig_fr;
    logic [3:0] acc_new;
    logic [3:0] code;
    logic       upd;
    logic [23:0] set_vec;
    logic [23:0] clr_vec;
    logic [6:0] ind_addr;
    logic       ind_hit;
    logic [4:0] ind_ch;

    // Bus request decode
    assign req  = WB_CYC_IN && WB_STB_IN && !ack_q;
    assign wr   = req && WB_WE_IN && WB_SEL_IN[0];
    assign widx = WB_ADR_IN[11:2];

    // Format and slot qualifiers; an out-of-range channel is not taken
    assign payload_ctrl_master_en    = ctrl_en_q[PAYLOAD_CTRL_MASTER_EN_BIT];
    assign sixteen = sig_cfg_q[SIXTEEN_STATE_SEL_BIT];
    assign sf_fmt  = (FORMAT_IN == FMT_SF);
    assign ext_fmt = (FORMAT_IN == FMT_ESF) || (FORMAT_IN == FMT_SLC96);
    assign in_ok   = SLOT_VALID_IN && (SLOT_IN.chan <= LAST_CH);
    assign ch      = in_ok ? SLOT_IN.chan : 5'h00;

    // Out-of-range indirect addresses read as zero and drop writes
    assign ind_addr = acc_ctrl_q[6:0];
    assign ind_hit  = (ind_addr >= IND_ADDR_MIN) && (ind_addr <= IND_ADDR_MAX);
    assign ind_ch   = ind_hit ? 5'(ind_addr - IND_ADDR_MIN) : 5'h00;

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ack_q <= 1'b0;
            rd_q  <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            rd_q  <= req ? rd_d : 32'h0000_0000;
        end
    end

    // Ack stands one cycle; read data is zero outside it
    assign WB_ACK_OUT = ack_q;
    assign WB_DAT_OUT = rd_q;

    // Read mux; reserved bits read as zero
    always_comb begin
        rd_d = 32'h0000_0000;
        case (widx)
            {2'b00, IDX_PAYLOAD_CFG}: rd_d[7:0] = payload_cfg_q & 8'hC7;
            {2'b00, IDX_CTRL_EN}:     rd_d[7:0] = ctrl_en_q & 8'h0F;
            {2'b00, IDX_SIG_CFG}:     rd_d[7:0] = sig_cfg_q & 8'h0F;
            {2'b00, IDX_ACC_STATUS}:  rd_d[BUSY_BIT] = (ind_q == IND_RUN);
            {2'b00, IDX_ACC_CTRL}:    rd_d[7:0] = acc_ctrl_q;
            {2'b00, IDX_ACC_DATA}:    rd_d[7:0] = acc_data_q;
            {2'b00, IDX_FLAGS_LO}:    rd_d[7:0] = flags_q[7:0];
            {2'b00, IDX_FLAGS_MID}:   rd_d[7:0] = flags_q[15:8];
            {2'b00, IDX_FLAGS_HI}:    rd_d[7:0] = flags_q[23:16];
            default:                  rd_d = 32'h0000_0000;
        endcase
    end

    // Configuration registers
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            payload_cfg_q <= PAYLOAD_CFG_RST;
            ctrl_en_q     <= CTRL_EN_RST;
            sig_cfg_q     <= SIG_CFG_RST;
        end else if (wr) begin
            if (widx == {2'b00, IDX_PAYLOAD_CFG}) begin
                payload_cfg_q <= WB_DAT_IN[7:0];
            end
            if (widx == {2'b00, IDX_CTRL_EN}) begin
                ctrl_en_q <= WB_DAT_IN[7:0];
            end
            if (widx == {2'b00, IDX_SIG_CFG}) begin
                sig_cfg_q <= WB_DAT_IN[7:0];
            end
        end
    end

    // Indirect access sequencer; a control write launches one operation
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            acc_ctrl_q <= ACC_RST;
            ind_q      <= IND_IDLE;
        end else begin
            unique case (ind_q)
                IND_IDLE: begin
                    if (wr && widx == {2'b00, IDX_ACC_CTRL}) begin
                        acc_ctrl_q <= WB_DAT_IN[7:0];
                        ind_q      <= IND_RUN;
                    end
                end
                IND_RUN: begin
                    ind_q <= IND_IDLE;
                end
            endcase
        end
    end

    // Access data: host writes it, an indirect read overwrites it
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            acc_data_q <= ACC_RST;
        end else if (ind_q == IND_RUN && acc_ctrl_q[RWN_BIT]) begin
            acc_data_q <= ind_hit ? store_q[ind_ch] : 8'h00;
        end else if (wr && widx == {2'b00, IDX_ACC_DATA}) begin
            acc_data_q <= WB_DAT_IN[7:0];
        end
    end

    // Signaling extraction from the robbed bit of signaling frames
    always_comb begin
        acc_new = acc_q[ch];
        done    = 1'b0;
        sig_fr  = 1'b0;
        if (in_ok && FRAME_SYNC_IN && (sf_fmt || ext_fmt)) begin
            if (SLOT_IN.frame == FR_A) begin
                acc_new[3] = SLOT_IN.data[0];
                sig_fr     = 1'b1;
            end else if (SLOT_IN.frame == FR_B) begin
                acc_new[2] = SLOT_IN.data[0];
                sig_fr     = 1'b1;
                done       = sf_fmt;
            end else if (SLOT_IN.frame == FR_C && ext_fmt) begin
                if (sixteen) begin
                    acc_new[1] = SLOT_IN.data[0];
                end else begin
                    acc_new[3] = SLOT_IN.data[0];
                end
                sig_fr = 1'b1;
            end else if (SLOT_IN.frame == FR_D && ext_fmt) begin
                if (sixteen) begin
                    acc_new[0] = SLOT_IN.data[0];
                end else begin
                    acc_new[2] = SLOT_IN.data[0];
                end
                sig_fr = 1'b1;
                done   = 1'b1;
            end
        end
    end

    // Completed codeword; SF repeats AB into the CD positions
    // Fixing replaces the extracted code before it is stored
    always_comb begin
        if (sf_fmt) begin
            code = {acc_new[3:2], acc_new[3:2]};
        end else if (sixteen) begin
            code = acc_new;
        end else begin
            code = {acc_new[3:2], 2'b00};
        end
        if (payload_ctrl_master_en && ctrl_en_q[FIX_BIT]) begin
            code = {4{ctrl_en_q[POL_BIT]}};
        end
    end

    // Debounce compares against the previous completed codeword
    // Freeze and a cleared extract enable both keep the store as it is
    assign upd = done && store_q[ch][EXT_EN_BIT] && !sig_cfg_q[FREEZE_BIT]
               && (!sig_cfg_q[DEB_BIT] || code == prev_q[ch]);

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < NUM_CH; i++) begin
                acc_q[i]  <= 4'h0;
                prev_q[i] <= 4'h0;
            end
        end else begin
            // Partial codewords build up per channel until the last frame
            if (sig_fr) begin
                acc_q[ch] <= acc_new;
            end
            if (done) begin
                prev_q[ch] <= code;
            end
        end
    end

    // Per-channel store; a host indirect write takes the cycle over extraction
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < NUM_CH; i++) begin
                store_q[i] <= STORE_RST;
            end
        end else if (ind_q == IND_RUN && !acc_ctrl_q[RWN_BIT]) begin
            if (ind_hit) begin
                store_q[ind_ch] <= acc_data_q;
            end
        end else if (upd) begin
            store_q[ch][3:0] <= code;
        end
    end

    // Change flags: hardware set wins over a same-cycle clear
    always_comb begin
        set_vec = 24'h00_0000;
        clr_vec = 24'h00_0000;
        if (upd && !(ind_q == IND_RUN && !acc_ctrl_q[RWN_BIT])
            && code != store_q[ch][3:0]) begin
            set_vec[ch] = 1'b1;
        end
        if (wr && widx == {2'b00, IDX_FLAGS_LO}) begin
            clr_vec[7:0] = WB_DAT_IN[7:0];
        end
        if (wr && widx == {2'b00, IDX_FLAGS_MID}) begin
            clr_vec[15:8] = WB_DAT_IN[7:0];
        end
        if (wr && widx == {2'b00, IDX_FLAGS_HI}) begin
            clr_vec[23:16] = WB_DAT_IN[7:0];
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            flags_q <= 24'h00_0000;
        end else begin
            flags_q <= (flags_q & ~clr_vec) | set_vec;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            INT_OUT <= 1'b0;
        end else begin
            // Level follows the flags one cycle later
            INT_OUT <= sig_cfg_q[SIGNALING_IRQ_EN_BIT] && (|flags_q);
        end
    end

    // Snapshot latch taken in the first frame of each multiframe
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            for (int i = 0; i < NUM_CH; i++) begin
                hold_q[i] <= 4'h0;
            end
        end else if (in_ok && SLOT_IN.frame == FR_FIRST) begin
            hold_q[ch] <= store_q[ch][3:0];
        end
    end

    // Milliwatt pattern phase advances once per frame
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            phase_q <= 3'h0;
        end else if (in_ok && SLOT_IN.chan == 5'h00) begin
            phase_q <= phase_q + 3'h1;
        end
    end

    // Outgoing slot
    logic [2:0] sub_sel;
    logic [7:0] data_d;
    logic [3:0] sig_d;

    always_comb begin
        // A nonzero global substitution code overrides the per-channel one
        sub_sel = (payload_cfg_q[GSUB_MSB:0] != SUB_NONE)
                ? payload_cfg_q[GSUB_MSB:0] : CH_CTRL_IN.channel_payload_substitution;
        data_d = SLOT_IN.data;
        if (payload_ctrl_master_en) begin
            unique case (sub_sel)
                SUB_TRUNK: data_d = CH_CTRL_IN.data_trunk_code;
                SUB_ALAW:  data_d = ALAW_MW[phase_q];
                SUB_ULAW:  data_d = ULAW_MW[phase_q];
                default:   data_d = SLOT_IN.data;
            endcase
        end
        if (payload_ctrl_master_en && payload_cfg_q[SNAP_BIT] && FRAME_SYNC_IN && (sf_fmt || ext_fmt)) begin
            // Frame one passes the live store while the latch takes it
            if (SLOT_IN.frame == FR_FIRST) begin
                sig_d = store_q[ch][3:0];
            end else begin
                sig_d = hold_q[ch];
            end
        end else begin
            sig_d = store_q[ch][3:0];
        end
        // Trunk code and two-bit placement act on top of the snapshot
        if (payload_ctrl_master_en && (payload_cfg_q[GSTRK_BIT] || CH_CTRL_IN.strk_en)) begin
            sig_d = CH_CTRL_IN.strk_code;
        end
        if (payload_ctrl_master_en && ext_fmt && ctrl_en_q[TWO_BIT_SIGNALING_PLACE_BIT]) begin
            sig_d = {sig_d[3:2], 2'b00};
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            SLOT_VALID_OUT <= 1'b0;
            SLOT_DATA_OUT  <= 8'h00;
            SLOT_SIG_OUT   <= 4'h0;
        end else begin
            // Every taken slot leaves one cycle later
            SLOT_VALID_OUT <= in_ok;
            SLOT_DATA_OUT  <= data_d;
            SLOT_SIG_OUT   <= sig_d;
        end
    end
endmodule : rps_rx_payload_signaling_ctrl

/* verification/rps_ctrl_props.sv */
`timescale 1ns/1ps
module rps_ctrl_props
    import rps_pkg::*;
(
    input wire logic        CLK_IN,
    input wire logic        RSTN_IN,
    input wire logic        WB_CYC_IN,
    input wire logic        WB_STB_IN,
    input wire logic        WB_WE_IN,
    input wire logic [11:0] WB_ADR_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic        WB_ACK_OUT,
    input wire logic        SLOT_VALID_IN,
    input wire rps_slot_t   SLOT_IN,
    input wire logic        SLOT_VALID_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    wire req  = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    wire take = SLOT_VALID_IN && (SLOT_IN.chan <= LAST_CH);
    wire far  = (WB_ADR_IN < 12'h340) || (WB_ADR_IN > 12'h363);
    property p_ack_resp;
        req |=> WB_ACK_OUT;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("No ack after request");
    property p_ack_pulse;
        WB_ACK_OUT |=> !WB_ACK_OUT;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("Ack longer than one cycle");
    property p_ack_cause;
        $rose(WB_ACK_OUT) |-> $past(WB_CYC_IN && WB_STB_IN);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("Ack without request");
    property p_dat_idle;
        !WB_ACK_OUT |-> WB_DAT_OUT == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("Read data outside ack");
    property p_dat_upper;
        WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0;
    endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("Upper read bits set");
    property p_unmapped;
        req && !WB_WE_IN && far |=> WB_ACK_OUT && WB_DAT_OUT == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero");
    property p_valid;
        take |=> SLOT_VALID_OUT ##1 (SLOT_VALID_OUT == $past(take));
    endproperty
    a_valid: assert property (p_valid) else $error("Slot not passed on");
    property p_invalid;
        !take |=> !SLOT_VALID_OUT;
    endproperty
    a_invalid: assert property (p_invalid) else $error("Spurious slot output");
endmodule : rps_ctrl_props

bind rps_rx_payload_signaling_ctrl rps_ctrl_props u_props (
    .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_OUT(WB_DAT_OUT),
    .WB_ACK_OUT(WB_ACK_OUT), .SLOT_VALID_IN(SLOT_VALID_IN), .SLOT_IN(SLOT_IN),
    .SLOT_VALID_OUT(SLOT_VALID_OUT)
);

/* verification/rps_slot_src.sv */
`timescale 1ns/1ps
module rps_slot_src
    import rps_pkg::*;
(
    input  wire logic CLK_IN,
    output logic      VALID_OUT,
    output rps_slot_t SLOT_OUT
);
    initial begin
        VALID_OUT = 1'b0;
        SLOT_OUT  = '0;
    end
    // One slot per call; idle slot lines show the inverse of the last slot
    task automatic send(input logic [4:0] ch, input logic [4:0] fr, input logic [7:0] d);
        @(posedge CLK_IN);
        VALID_OUT <= 1'b1;
        SLOT_OUT  <= '{chan: ch, frame: fr, data: d};
        @(posedge CLK_IN);
        VALID_OUT <= 1'b0;
        SLOT_OUT  <= ~SLOT_OUT;
    endtask : send
endmodule : rps_slot_src

/* verification/tb_rx_payload_signaling_ctrl.sv */
`timescale 1ns/1ps
module tb_rx_payload_signaling_ctrl
    import rps_pkg::*;
;
    logic        clk, rstn, cyc, stb, we, ack, vld, sync, vo, intr;
    logic [11:0] adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  dout;
    logic [3:0]  sig;
    rps_slot_t   slot_w;
    rps_chctl_t  chc;
    rps_fmt_t    fmt;
    int          failures, comparisons, cycles;

    rps_slot_src src (.CLK_IN(clk), .VALID_OUT(vld), .SLOT_OUT(slot_w));
    rps_rx_payload_signaling_ctrl dut (
        .CLK_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .SLOT_VALID_IN(vld), .SLOT_IN(slot_w), .CH_CTRL_IN(chc),
        .FORMAT_IN(fmt), .FRAME_SYNC_IN(sync), .SLOT_VALID_OUT(vo),
        .SLOT_DATA_OUT(dout), .SLOT_SIG_OUT(sig), .INT_OUT(intr)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d,
                      output logic [7:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {2'h0, i, 2'h0};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, i, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] i, input logic [7:0] e, input string nm);
        logic [7:0] q;
        wb(1'b0, i, 8'h00, q);
        chk(nm, e, q);
    endtask : rd

    task automatic ind_rd(input logic [7:0] a, input logic [7:0] e);
        wr(IDX_ACC_CTRL, 8'h80 | a);
        rd(IDX_ACC_DATA, e, "store");
    endtask : ind_rd

    task automatic slot(input logic [4:0] ch, input logic [7:0] d);
        src.send(ch, 5'h01, d);
        @(posedge clk);
    endtask : slot

    // Signaling bit of the first n of frames 6, 12, 18, 24 taken from b, msb first
    task automatic mf(input logic [4:0] ch, input logic [3:0] b, input int n);
        for (int k = 0; k < n; k++) begin
            src.send(ch, 5'(6 * (k + 1)), {7'h0, b[3 - k]});
        end
        repeat (2) @(posedge clk);
    endtask : mf

    task automatic t_reset();
        for (int i = 0; i < 9; i++) begin
            rd(IDX_PAYLOAD_CFG + 8'(i), (i == 0) ? PAYLOAD_CFG_RST :
               (i == 2) ? SIG_CFG_RST : ACC_RST, "reset value");
        end
        rd(8'h10, 8'h00, "unmapped");
        wr(IDX_ACC_STATUS, 8'hFF);
        rd(IDX_ACC_STATUS, 8'h00, "status");
        wr(IDX_SIG_CFG, 8'hFF);
        rd(IDX_SIG_CFG, 8'h0F, "sig cfg");
        ind_rd(8'h01, STORE_RST);
    endtask : t_reset

    task automatic t_channel_payload_substitution();
        logic [7:0] e [5];
        e = '{8'hC3, 8'hC3, ALAW_MW[0], ULAW_MW[0], 8'h5A};
        chc <= '{channel_payload_substitution: 3'h1, data_trunk_code: 8'hC3, strk_en: 1'b0, strk_code: 4'h9};
        wr(IDX_CTRL_EN, 8'h01);
        for (int g = 0; g < 5; g++) begin
            wr(IDX_PAYLOAD_CFG, 8'(g));
            slot(5'h01, 8'h5A);
            chk("payload", e[g], dout);
        end
        wr(IDX_PAYLOAD_CFG, 8'h41);
        slot(5'h01, 8'h5A);
        chk("trunk sig", 8'h09, {4'h0, sig});
        wr(IDX_CTRL_EN, 8'h00);
        slot(5'h01, 8'h5A);
        chk("master off", 8'h5A, dout);
        wr(IDX_PAYLOAD_CFG, 8'h00);
    endtask : t_channel_payload_substitution

    task automatic t_sig();
        rps_fmt_t   f [10] = '{FMT_SF, FMT_SF, FMT_SF, FMT_SF, FMT_ESF,
                               FMT_SLC96, FMT_ESF, FMT_SF, FMT_ESF, FMT_ESF};
        logic [7:0] c1 [10] = '{8'h07, 8'h05, 8'h03, 8'h04, 8'h01,
                                8'h01, 8'h01, 8'h07, 8'h01, 8'h01};
        logic [7:0] c2 [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
                                8'h00, 8'h09, 8'h01, 8'h05, 8'h05};
        logic [4:0] ch [10] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
                                5'h07, 5'h08, 5'h10, 5'h09, 5'h09};
        logic [3:0] b  [10] = '{4'h0, 4'hC, 4'h8, 4'h4, 4'hB, 4'hF, 4'hF, 4'h0, 4'hF, 4'hF};
        logic [7:0] e  [10] = '{8'h1F, 8'h10, 8'h1A, 8'h15, 8'h1B,
                                8'h1C, 8'h10, 8'h1F, 8'h10, 8'h1F};
        for (int c = 0; c < 10; c++) begin
            fmt <= f[c];
            wr(IDX_CTRL_EN, c1[c]);
            wr(IDX_SIG_CFG, c2[c]);
            mf(ch[c], b[c], (f[c] == FMT_SF) ? 2 : 4);
            ind_rd({3'h0, ch[c]} + 8'h01, e[c]);
        end
        wr(IDX_CTRL_EN, 8'h09);
        slot(5'h06, 8'h00);
        chk("two bit place", 8'h08, {4'h0, sig});
        wr(IDX_CTRL_EN, 8'h01);
        wr(IDX_PAYLOAD_CFG, 8'h80);
        slot(5'h06, 8'h00);
        chk("snapshot first", 8'h0B, {4'h0, sig});
        wr(IDX_ACC_DATA, 8'h13);
        wr(IDX_ACC_CTRL, 8'h07);
        src.send(5'h06, 5'h02, 8'h00);
        @(posedge clk);
        chk("snapshot hold", 8'h0B, {4'h0, sig});
        chk("slot valid", 8'h01, {7'h0, vo});
        wr(IDX_PAYLOAD_CFG, 8'h00);
    endtask : t_sig

    task automatic t_flags();
        rd(IDX_FLAGS_LO, 8'hF4, "flags lo");
        rd(IDX_FLAGS_MID, 8'h02, "flags mid");
        rd(IDX_FLAGS_HI, 8'h01, "flags hi");
        chk("irq off", 8'h00, {7'h0, intr});
        wr(IDX_SIG_CFG, 8'h03);
        repeat (2) @(posedge clk);
        chk("irq on", 8'h01, {7'h0, intr});
        wr(IDX_FLAGS_LO, 8'h00);
        rd(IDX_FLAGS_LO, 8'hF4, "w0 keeps");
        wr(IDX_FLAGS_LO, 8'hF4);
        wr(IDX_FLAGS_MID, 8'h02);
        wr(IDX_FLAGS_HI, 8'h01);
        rd(IDX_FLAGS_MID, 8'h00, "w1 clears");
        chk("irq clear", 8'h00, {7'h0, intr});
    endtask : t_flags

    task automatic t_ind();
        wr(IDX_ACC_DATA, 8'h3A);
        wr(IDX_ACC_CTRL, 8'h0C);
        rd(IDX_ACC_STATUS, 8'h00, "busy");
        rd(IDX_ACC_CTRL, 8'h0C, "acc ctrl");
        ind_rd(8'h0C, 8'h3A);
        ind_rd(8'h19, 8'h00);
    endtask : t_ind

    initial begin
        {cyc, stb, we, rstn, failures, comparisons} = '0;
        {adr, wdat, chc} = '0;
        fmt  = FMT_SF;
        sync = 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_channel_payload_substitution();
        t_sig();
        t_flags();
        t_ind();
        wrap_up();
    end
endmodule : tb_rx_payload_signaling_ctrl
